//--- hwd_defs.svh
// Register offsets, field positions, reset values and step counts of the hardware divider.
`ifndef HWD_DEFS_SVH
`define HWD_DEFS_SVH

`define HWD_ADDR_W 8
`define HWD_WORD_W 32
`define HWD_OFF_CTRL 8'h00
`define HWD_OFF_DVD_LO 8'h04
`define HWD_OFF_DVD_HI 8'h08
`define HWD_OFF_DVS 8'h0c
`define HWD_OFF_QUO_LO 8'h10
`define HWD_OFF_QUO_HI 8'h14
`define HWD_OFF_REM 8'h18
`define HWD_OFF_IRQ_STAT 8'h1c
`define HWD_OFF_IRQ_MASK 8'h20

`define HWD_BIT_START 0
`define HWD_BIT_MODE 4
`define HWD_BIT_DONE 8
`define HWD_BIT_BUSY 9
`define HWD_BIT_DBZ 10

`define HWD_EVT_DONE 0
`define HWD_EVT_DBZ 1
`define HWD_EVT_W 2

`define HWD_RESET_WORD 32'h0000_0000
`define HWD_OP_CYCLES 32
`define HWD_CNT_W 5
`define HWD_LAST_STEP 5'h1f

`endif

//--- hwd_pkg.sv
// Types shared by the hardware divider modules.
package hwd_pkg;
    typedef logic [7:0] hwd_addr_t;
    typedef logic [31:0] hwd_word_t;
    typedef logic [63:0] hwd_dword_t;
    typedef enum logic [1:0] {
        HWD_IDLE = 2'b01,
        HWD_RUN = 2'b10
    } hwd_state_t;
endpackage

//--- hwd_eng_if.sv
// Carrier between the register front end and the iterative division engine.
`timescale 1ns/1ps
interface hwd_eng_if;
    logic start;
    logic [63:0] dividend;
    logic [31:0] divisor;
    logic busy;
    logic fin;
    logic [63:0] quotient;
    logic [31:0] remainder;
    logic [4:0] step_cnt;
    modport eng (input start, input dividend, input divisor,
                 output busy, output fin, output quotient, output remainder, output step_cnt);
    modport ctl (output start, output dividend, output divisor,
                 input busy, input fin, input quotient, input remainder, input step_cnt);
endinterface

//--- hwd_engine.sv
// Iterative restoring divider engine, two quotient bits per clock.
`timescale 1ns/1ps
`include "hwd_defs.svh"
module hwd_engine (
    // Clock, reset and enable.
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    // Link to the register front end.
    hwd_eng_if.eng eng
);
    import hwd_pkg::*;

    hwd_state_t state;
    logic [4:0] cnt;
    logic [95:0] acc;
    logic [31:0] dvs;
    logic [95:0] next_acc;
    logic last;

    // One shift-and-subtract step on {remainder, dividend shift register}.
    function automatic logic [95:0] div_step(input logic [95:0] a, input logic [31:0] d);
        logic [32:0] r;
        logic [32:0] diff;
        r = a[95:63];
        diff = r - {1'b0, d};
        if (r >= {1'b0, d}) begin
            div_step = {diff[31:0], a[62:0], 1'b1};
        end else begin
            div_step = {r[31:0], a[62:0], 1'b0};
        end
    endfunction

    assign next_acc = div_step(div_step(acc, dvs), dvs);
    assign last = (state == HWD_RUN) && (cnt == `HWD_LAST_STEP);
    assign eng.busy = (state == HWD_RUN);
    assign eng.fin = last;
    assign eng.step_cnt = cnt;

    // Sequencer; a start while running is dropped.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            state <= HWD_IDLE;
        end else if (ce_i) begin
            case (state)
                HWD_IDLE: begin
                    if (eng.start) begin
                        state <= HWD_RUN;
                    end
                end
                HWD_RUN: begin
                    if (last) begin
                        state <= HWD_IDLE;
                    end
                end
                default: begin
                    state <= HWD_IDLE;
                end
            endcase
        end
    end

    // Step counter.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= 5'h00;
        end else if (ce_i) begin
            if (state == HWD_IDLE) begin
                cnt <= 5'h00;
            end else begin
                cnt <= cnt + 5'h01;
            end
        end
    end

    // Operand capture and the working accumulator.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            acc <= 96'h0;
            dvs <= 32'h0;
        end else if (ce_i) begin
            if (state == HWD_IDLE && eng.start) begin
                // unsigned operands, remainder starts at zero.
                acc <= {32'h0, eng.dividend};
                dvs <= eng.divisor;
            end else if (state == HWD_RUN) begin
                acc <= next_acc;
            end
        end
    end

    // results held until the next completion.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            eng.quotient <= 64'h0;
            eng.remainder <= 32'h0;
        end else if (ce_i && last) begin
            eng.quotient <= next_acc[63:0];
            eng.remainder <= next_acc[95:64];
        end
    end
endmodule

//--- hwd_top.sv
// Memory-mapped 64 by 32 unsigned hardware divider with register front end.
`timescale 1ns/1ps
`include "hwd_defs.svh"
module hwd_top (
    // Clock, reset and enable.
    input wire logic CORE_CLK_I,
    input wire logic SYS_RST_I,
    input wire logic CORE_CE_I,
    // Register port.
    input wire hwd_pkg::hwd_addr_t REG_ADDR_I,
    input wire hwd_pkg::hwd_word_t REG_WDATA_I,
    input wire logic REG_WR_I,
    input wire logic REG_RD_I,
    output hwd_pkg::hwd_word_t REG_RDATA_O,
    // Interrupt.
    output logic IRQ_O
);
    import hwd_pkg::*;

    hwd_eng_if eng_bus ();

    hwd_word_t dividend_low;
    hwd_word_t dividend_high;
    hwd_word_t divisor_value;
    logic mode;
    logic done_flag;
    logic dbz_flag;
    logic dbz_pend;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] next_stat;
    logic [1:0] evt;
    logic wr_ctrl;
    logic wr_dvs;
    logic trig;
    logic go;
    hwd_word_t ctrl_view;
    hwd_word_t next_rdata;

    // Address decode of writes.
    function automatic logic hit(input hwd_addr_t a, input hwd_addr_t off);
        hit = (a == off);
    endfunction

    assign wr_ctrl = REG_WR_I && hit(REG_ADDR_I, `HWD_OFF_CTRL);
    assign wr_dvs = REG_WR_I && hit(REG_ADDR_I, `HWD_OFF_DVS);

    // Start trigger selection.
    // manual start bit in mode 0.
    // divisor write starts in mode 1.
    // start bit ignored in mode 1.
    assign trig = mode ? wr_dvs : (wr_ctrl && REG_WDATA_I[`HWD_BIT_START]);
    assign go = trig && !eng_bus.busy;

    // Operands to the engine; a divisor write in auto mode takes the new value.
    // high word on top, low word below.
    assign eng_bus.start = go;
    assign eng_bus.dividend = {dividend_high, dividend_low};
    assign eng_bus.divisor = wr_dvs ? REG_WDATA_I : divisor_value;

    hwd_engine u_engine (
        .clk_i (CORE_CLK_I),
        .rst_i (SYS_RST_I),
        .ce_i (CORE_CE_I),
        .eng (eng_bus.eng)
    );

    // Operand registers; the engine holds its own copy, so rewriting them mid-run is harmless.
    // the divisor write is what launches in auto mode.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            dividend_low <= `HWD_RESET_WORD;
            dividend_high <= `HWD_RESET_WORD;
            divisor_value <= `HWD_RESET_WORD;
        end else if (CORE_CE_I && REG_WR_I) begin
            if (hit(REG_ADDR_I, `HWD_OFF_DVD_LO)) begin
                dividend_low <= REG_WDATA_I;
            end
            if (hit(REG_ADDR_I, `HWD_OFF_DVD_HI)) begin
                dividend_high <= REG_WDATA_I;
            end
            if (hit(REG_ADDR_I, `HWD_OFF_DVS)) begin
                divisor_value <= REG_WDATA_I;
            end
        end
    end

    // Trigger mode bit of the control register.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            mode <= 1'b0;
        end else if (CORE_CE_I && wr_ctrl) begin
            mode <= REG_WDATA_I[`HWD_BIT_MODE];
        end
    end

    // Completion and divide-by-zero flags.
    // start clears, completion sets done.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            done_flag <= 1'b0;
            dbz_flag <= 1'b0;
            dbz_pend <= 1'b0;
        end else if (CORE_CE_I) begin
            if (go) begin
                done_flag <= 1'b0;
                dbz_flag <= 1'b0;
                dbz_pend <= (eng_bus.divisor == 32'h0);
            end else if (eng_bus.fin) begin
                done_flag <= 1'b1;
                dbz_flag <= dbz_pend;
            end
        end
    end

    // Interrupt events: a done pulse, and a done pulse with a zero divisor.
    assign evt = {eng_bus.fin && dbz_pend, eng_bus.fin};

    // Sticky status, write one to clear; a new event beats the clear.
    always_comb begin
        next_stat = irq_stat;
        if (REG_WR_I && hit(REG_ADDR_I, `HWD_OFF_IRQ_STAT)) begin
            next_stat = irq_stat & ~REG_WDATA_I[1:0];
        end
        next_stat = next_stat | evt;
    end

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            irq_stat <= 2'h0;
        end else if (CORE_CE_I) begin
            irq_stat <= next_stat;
        end
    end

    // Interrupt mask register.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            irq_mask <= 2'h0;
        end else if (CORE_CE_I && REG_WR_I && hit(REG_ADDR_I, `HWD_OFF_IRQ_MASK)) begin
            irq_mask <= REG_WDATA_I[1:0];
        end
    end

    // Level interrupt while an unmasked status bit is set.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            IRQ_O <= 1'b0;
        end else if (CORE_CE_I) begin
            IRQ_O <= |(next_stat & irq_mask);
        end
    end

    // Control register view; the start bit reads zero.
    // busy on bit 9.
    always_comb begin
        ctrl_view = `HWD_RESET_WORD;
        ctrl_view[`HWD_BIT_MODE] = mode;
        ctrl_view[`HWD_BIT_DONE] = done_flag;
        ctrl_view[`HWD_BIT_BUSY] = eng_bus.busy;
        ctrl_view[`HWD_BIT_DBZ] = dbz_flag;
    end

    // Read multiplexer; unmapped offsets read zero.
    // low quotient word.
    always_comb begin
        case (REG_ADDR_I)
            `HWD_OFF_CTRL: next_rdata = ctrl_view;
            `HWD_OFF_DVD_LO: next_rdata = dividend_low;
            `HWD_OFF_DVD_HI: next_rdata = dividend_high;
            `HWD_OFF_DVS: next_rdata = divisor_value;
            `HWD_OFF_QUO_LO: next_rdata = eng_bus.quotient[31:0];
            `HWD_OFF_QUO_HI: next_rdata = eng_bus.quotient[63:32];
            `HWD_OFF_REM: next_rdata = eng_bus.remainder;
            `HWD_OFF_IRQ_STAT: next_rdata = {30'h0, irq_stat};
            `HWD_OFF_IRQ_MASK: next_rdata = {30'h0, irq_mask};
            default: next_rdata = `HWD_RESET_WORD;
        endcase
    end

    // Read data stands in the cycle after the strobe only.
    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            REG_RDATA_O <= `HWD_RESET_WORD;
        end else if (CORE_CE_I) begin
            REG_RDATA_O <= REG_RD_I ? next_rdata : `HWD_RESET_WORD;
        end
    end

    // Reference copies of the operands for checking results.
    hwd_word_t ref_hi;
    hwd_word_t ref_lo;
    hwd_word_t ref_b;

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            ref_hi <= `HWD_RESET_WORD;
            ref_lo <= `HWD_RESET_WORD;
            ref_b <= `HWD_RESET_WORD;
        end else if (CORE_CE_I && go) begin
            ref_hi <= dividend_high;
            ref_lo <= dividend_low;
            ref_b <= eng_bus.divisor;
        end
    end

    // Independent count of busy cycles since the start; it freezes with the clock enable like the engine.
    logic [5:0] run_len;

    always_ff @(posedge CORE_CLK_I) begin
        if (SYS_RST_I) begin
            run_len <= 6'h00;
        end else if (CORE_CE_I) begin
            if (go) begin
                run_len <= 6'h00;
            end else if (eng_bus.busy) begin
                run_len <= run_len + 6'h01;
            end
        end
    end

    // Completion is visible one edge after the 32nd busy cycle.
    a_done_latency: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        go |-> (##33 (done_flag && !eng_bus.busy)))
        else $error("done not set 32 cycles after start");

    // The last step falls in the 32nd busy cycle, pauses excluded.
    a_run_length: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        eng_bus.fin |-> (run_len == 6'h1f))
        else $error("division did not take 32 cycles");

    // Busy holds through all 32 cycles of the run.
    a_busy_hold: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        go |=> eng_bus.busy [*8] ##1 eng_bus.busy [*8] ##1 eng_bus.busy [*8] ##1 eng_bus.busy [*8])
        else $error("busy dropped during a division");

    // Starting clears the done and zero flags.
    a_start_clear: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        go |=> (!done_flag && !dbz_flag && eng_bus.busy))
        else $error("start did not clear flags or set busy");

    // Done and busy never stand together.
    a_done_busy_excl: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        !(done_flag && eng_bus.busy))
        else $error("done and busy both high");

    // Quotient matches the reference division.
    a_quot_value: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        ($rose(done_flag) && ref_b != 32'h0) |->
        eng_bus.quotient == ({ref_hi, ref_lo} / {32'h0, ref_b}))
        else $error("quotient wrong");

    // Remainder matches the reference division.
    a_rem_value: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        ($rose(done_flag) && ref_b != 32'h0) |->
        {32'h0, eng_bus.remainder} == ({ref_hi, ref_lo} % {32'h0, ref_b}))
        else $error("remainder wrong");

    // Results stay put while a division is still running.
    a_result_hold: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        (eng_bus.busy && !eng_bus.fin) |=> ($stable(eng_bus.quotient) && $stable(eng_bus.remainder)))
        else $error("results changed before completion");

    // Zero flag follows the divisor of the finished operation.
    a_dbz_value: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        $rose(done_flag) |-> (dbz_flag == (ref_b == 32'h0)))
        else $error("divide by zero flag wrong");

    // A zero-divisor completion raises both the flag and its status bit.
    a_dbz_event: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        (eng_bus.fin && dbz_pend) |=> (dbz_flag && irq_stat[`HWD_EVT_DBZ]))
        else $error("zero divisor event lost");

    // Every completion sets the done status bit, even against a clear.
    a_done_event: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        eng_bus.fin |=> (done_flag && irq_stat[`HWD_EVT_DONE]))
        else $error("done event lost");

    // A control read returns the busy state of the read cycle.
    a_busy_read: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        (REG_RD_I && REG_ADDR_I == `HWD_OFF_CTRL) |=> (REG_RDATA_O[`HWD_BIT_BUSY] == $past(eng_bus.busy)))
        else $error("busy bit read wrong");

    // Read data is zero outside the cycle after a read strobe.
    a_rdata_quiet: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        !REG_RD_I |=> (REG_RDATA_O == 32'h0000_0000))
        else $error("read data outside its cycle");

    // In manual mode a start bit write from idle launches a run.
    a_manual_start: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        (!mode && wr_ctrl && REG_WDATA_I[`HWD_BIT_START] && !eng_bus.busy) |=>
        (eng_bus.busy && eng_bus.step_cnt == 5'h00))
        else $error("start bit did not start");

    // In auto mode a start bit write alone does nothing.
    a_start_ignored: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        (mode && wr_ctrl && REG_WDATA_I[`HWD_BIT_START] && !wr_dvs && !eng_bus.busy) |=>
        !eng_bus.busy)
        else $error("start bit launched in auto mode");

    // In auto mode a divisor write from idle launches a run.
    a_auto_start: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        (mode && wr_dvs && !eng_bus.busy) |=> (eng_bus.busy && eng_bus.step_cnt == 5'h00))
        else $error("divisor write did not start");

    // A trigger mid-run leaves the step count advancing.
    a_no_restart: assert property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I || !CORE_CE_I)
        (trig && eng_bus.busy && !eng_bus.fin) |=> (eng_bus.step_cnt == $past(eng_bus.step_cnt) + 5'h01))
        else $error("running division disturbed");

    // Main scenarios.
    c_manual_run: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (!mode && go) ##33 done_flag);
    c_auto_run: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        (mode && go) ##33 done_flag);
    c_paused_run: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        eng_bus.busy && !CORE_CE_I);
    c_zero_div: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        $rose(dbz_flag));
    c_busy_trig: cover property (@(posedge CORE_CLK_I) disable iff (SYS_RST_I)
        trig && eng_bus.busy);
endmodule

//--- hwd_top_tb.sv
// Self-checking testbench for the memory-mapped hardware divider.
`timescale 1ns/1ps
`include "hwd_defs.svh"
module hwd_top_tb;
    import hwd_pkg::*;
    logic clk;
    logic rst;
    logic ce;
    hwd_addr_t addr;
    hwd_word_t wdata;
    logic wr;
    logic rd;
    hwd_word_t rdata;
    logic irq;
    int fails;
    int samples_checked;
    int mode;
    logic [31:0] lfsr;
    // Behavioural model results, quotient then remainder, in issue order.
    logic [63:0] model_q[$];

    // Device under test.
    hwd_top dut (
        .CORE_CLK_I(clk),
        .SYS_RST_I(rst),
        .CORE_CE_I(ce),
        .REG_ADDR_I(addr),
        .REG_WDATA_I(wdata),
        .REG_WR_I(wr),
        .REG_RD_I(rd),
        .REG_RDATA_O(rdata),
        .IRQ_O(irq)
    );

    // Clock at 200 MHz.
    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // Next pseudo-random word from the shift register.
    function automatic logic [31:0] rnd(inout logic [31:0] s);
        s = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
        return s;
    endfunction

    // Compares one value and counts the outcome.
    task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            fails++;
            $display("Error %s expected %h seen %h", name, exp, seen);
        end
    endtask

    // Prints the counts and the verdict, then ends the run.
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", samples_checked, fails);
        if (fails == 0 && samples_checked > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    // One register write cycle; returns at the edge that takes it.
    task automatic reg_wr(input hwd_addr_t a, input hwd_word_t d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
    endtask

    // One register read cycle; data sampled in the cycle after the taking edge.
    task automatic reg_rd(input hwd_addr_t a, output hwd_word_t d);
        @(posedge clk);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask

    // Runs one division, checks flags, timing and results against the model.
    task automatic run_op(input logic [63:0] a, input logic [31:0] b, input bit retrig, input bit stall);
        hwd_addr_t ta;
        hwd_word_t td;
        hwd_word_t d;
        int n;
        int exp_n;
        logic dbz;
        logic [63:0] q;
        ta = (mode != 0) ? `HWD_OFF_DVS : `HWD_OFF_CTRL;
        td = (mode != 0) ? b : 32'h0000_0001;
        dbz = (b == 32'h0);
        // The model queues the quotient, and the remainder when the divisor is not zero.
        model_q.push_back(dbz ? 64'hffff_ffff_ffff_ffff : a / b);
        if (!dbz) begin
            model_q.push_back(a % b);
        end
        exp_n = `HWD_OP_CYCLES;
        reg_wr(`HWD_OFF_IRQ_STAT, 32'h0000_0003);
        reg_wr(`HWD_OFF_DVD_LO, a[31:0]);
        reg_wr(`HWD_OFF_DVD_HI, a[63:32]);
        if (mode == 0) begin
            reg_wr(`HWD_OFF_DVS, b);
        end
        reg_wr(ta, td);
        reg_rd(`HWD_OFF_CTRL, d);
        check("run flags", d[10:8], 3'b010);
        n = 2;
        if (retrig) begin
            reg_wr(ta, td);
            n = n + 2;
        end
        if (stall) begin
            @(posedge clk);
            ce <= 1'b0;
            repeat (4) @(posedge clk);
            ce <= 1'b1;
            n = n + 5;
            exp_n = exp_n + 4;
        end
        #1;
        while (irq !== 1'b1 && n < 200) begin
            @(posedge clk);
            n++;
            #1;
        end
        check("cycles", n, exp_n);
        reg_rd(`HWD_OFF_CTRL, d);
        check("end flags", d, {21'h0, dbz, 2'b01, 3'h0, mode[0], 4'h0});
        reg_rd(`HWD_OFF_IRQ_STAT, d);
        check("status", d, {30'h0, dbz, 1'b1});
        q = model_q.pop_front();
        reg_rd(`HWD_OFF_QUO_LO, d);
        check("quot lo", d, q[31:0]);
        reg_rd(`HWD_OFF_QUO_HI, d);
        check("quot hi", d, q[63:32]);
        if (!dbz) begin
            reg_rd(`HWD_OFF_REM, d);
            check("remainder", d, model_q.pop_front());
        end
    endtask

    // Watchdog against a hung handshake.
    initial begin
        repeat (20000) @(posedge clk);
        fails++;
        complete_run();
    end

    // Main sequence.
    initial begin
        hwd_word_t d;
        logic [63:0] a;
        logic [31:0] b;
        fails = 0;
        samples_checked = 0;
        mode = 0;
        lfsr = 32'h6de8;
        rst = 1'b1;
        ce = 1'b1;
        addr = 8'h00;
        wdata = 32'h0;
        wr = 1'b0;
        rd = 1'b0;
        repeat (12) @(posedge clk);
        rst <= 1'b0;
        // Reset values, with one unmapped place at the end.
        for (int i = 0; i <= 9; i++) begin
            reg_rd(8'(i * 4), d);
            check("reset value", d, 32'h0);
        end
        check("irq reset", irq, 1'b0);
        // Writes to read-only and unmapped places are dropped.
        reg_wr(`HWD_OFF_QUO_LO, 32'h5a5a_a5a5);
        reg_wr(8'h24, 32'h1234_5678);
        reg_rd(`HWD_OFF_QUO_LO, d);
        check("ro write", d, 32'h0);
        reg_rd(8'h24, d);
        check("unmapped", d, 32'h0);
        // Masked event leaves the interrupt low until unmasked, then W1C clears it.
        reg_wr(`HWD_OFF_DVD_LO, 32'h0000_0064);
        reg_wr(`HWD_OFF_DVS, 32'h0000_0007);
        reg_wr(`HWD_OFF_CTRL, 32'h0000_0001);
        repeat (40) @(posedge clk);
        #1;
        check("irq masked", irq, 1'b0);
        reg_rd(`HWD_OFF_IRQ_STAT, d);
        check("status sticky", d, 32'h1);
        reg_wr(`HWD_OFF_IRQ_MASK, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1;
        check("irq unmasked", irq, 1'b1);
        reg_wr(`HWD_OFF_IRQ_STAT, 32'h0000_0001);
        repeat (2) @(posedge clk);
        #1;
        check("irq cleared", irq, 1'b0);
        reg_wr(`HWD_OFF_IRQ_MASK, 32'h0000_0003);
        // Manual start: boundary operands, zero divisor, a retrigger and a pause.
        run_op(64'hffff_ffff_ffff_ffff, 32'h0000_0001, 1'b0, 1'b0);
        run_op(64'hffff_ffff_ffff_ffff, 32'hffff_ffff, 1'b1, 1'b0);
        run_op(64'h0000_0000_0000_0005, 32'h0000_0009, 1'b0, 1'b0);
        run_op(64'h1234_5678_9abc_def0, 32'h0000_0000, 1'b0, 1'b0);
        run_op(64'h8000_0000_0000_0000, 32'h8000_0001, 1'b0, 1'b1);
        for (int i = 0; i < 6; i++) begin
            a = {rnd(lfsr), rnd(lfsr)};
            b = rnd(lfsr) >> (rnd(lfsr) % 28);
            run_op(a, b, 1'b0, 1'b0);
        end
        // Auto mode: the start bit alone does nothing.
        reg_wr(`HWD_OFF_CTRL, 32'h0000_0010);
        mode = 1;
        reg_wr(`HWD_OFF_CTRL, 32'h0000_0011);
        reg_rd(`HWD_OFF_CTRL, d);
        check("start ignored", d, 32'h0000_0110);
        run_op(64'h0000_0001_0000_0000, 32'h0000_0000, 1'b0, 1'b0);
        run_op(64'h0000_0001_0000_0003, 32'h0000_0002, 1'b1, 1'b0);
        for (int i = 0; i < 4; i++) begin
            a = {rnd(lfsr), rnd(lfsr)};
            b = rnd(lfsr) >> (rnd(lfsr) % 28);
            run_op(a, b, 1'b0, 1'b0);
        end
        complete_run();
    end
endmodule
